// ---- cmsu_pkg.sv ----
// Register map, field layout and shared types of the counter match set unit.
package cmsu_pkg;

    // Sizes of the unit.
    localparam int unsigned NUM_SLOTS = 7;
    localparam int unsigned NUM_AXES = 3;
    localparam int unsigned NUM_VEC = 8;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned TBIT_W = 32;
    localparam int unsigned STAT_W = 8;

    // Target bit space: direct outputs, scan-delayed outputs, marker bits.
    localparam int unsigned DIRECT_LO = 0;
    localparam int unsigned DIRECT_W = 8;
    localparam int unsigned DELAY_LO = 8;
    localparam int unsigned DELAY_W = 8;
    localparam int unsigned MARK_LO = 16;
    localparam int unsigned MARK_W = 16;

    // Byte addresses of the registers.
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h008;
    localparam logic [11:0] ADDR_TBITS = 12'h00c;
    localparam logic [11:0] ADDR_SLOT_BASE = 12'h010;
    localparam logic [11:0] ADDR_SLOT_END = 12'h048;

    // Field positions.
    localparam int unsigned CTRL_MASK_BIT = 0;
    localparam int unsigned STAT_ERR_BIT = 7;

    // Values after reset.
    localparam logic CTRL_MASK_RST = 1'b0;
    localparam logic [STAT_W-1:0] STAT_RST = 8'h00;
    localparam logic [STAT_W-1:0] IRQ_MASK_RST = 8'h00;
    localparam logic [TBIT_W-1:0] TBITS_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] VAL_RST = 32'h0000_0000;

    // Bus encodings.
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        SRC_COUNTER = 2'h0,
        SRC_OUT_POS = 2'h1,
        SRC_CAM_POS = 2'h2,
        SRC_NONE = 2'h3
    } cmsu_src_e;

    typedef enum logic [1:0] {
        TGT_BIT = 2'h0,
        TGT_IRQ = 2'h1,
        TGT_CAM = 2'h2,
        TGT_NONE = 2'h3
    } cmsu_tgt_e;

    typedef struct packed {
        logic [4:0] idx;
        cmsu_tgt_e tgt;
        cmsu_src_e src;
        logic [1:0] axis;
        logic en;
    } cmsu_cfg_s;

    localparam cmsu_cfg_s CFG_RST = '{idx: 5'h00, tgt: TGT_BIT, src: SRC_COUNTER, axis: 2'h0,
                                      en: 1'b0};

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
    } cmsu_aphase_s;

endpackage : cmsu_pkg

// ---- cmsu_slot_cmp.sv ----
// Equality check of one compare slot against its selected axis counter.
module cmsu_slot_cmp (
    // Slot programming.
    input wire cmsu_pkg::cmsu_cfg_s cfg_in,
    input wire logic [cmsu_pkg::CNT_W-1:0] value_in,
    // Axis counters and their pulse-driven update strobes.
    input wire logic [cmsu_pkg::NUM_AXES*cmsu_pkg::CNT_W-1:0] cnt_in,
    input wire logic [cmsu_pkg::NUM_AXES-1:0] pulse_upd_in,
    // Match found in this cycle.
    output logic hit_out
);

    logic [cmsu_pkg::CNT_W-1:0] sel_cnt;
    logic sel_upd;

    always_comb begin
        sel_cnt = '0;
        sel_upd = 1'b0;
        case (cfg_in.axis)
            2'h0: begin
                sel_cnt = cnt_in[0*cmsu_pkg::CNT_W +: cmsu_pkg::CNT_W];
                sel_upd = pulse_upd_in[0];
            end
            2'h1: begin
                sel_cnt = cnt_in[1*cmsu_pkg::CNT_W +: cmsu_pkg::CNT_W];
                sel_upd = pulse_upd_in[1];
            end
            2'h2: begin
                sel_cnt = cnt_in[2*cmsu_pkg::CNT_W +: cmsu_pkg::CNT_W];
                sel_upd = pulse_upd_in[2];
            end
            default: begin
                sel_cnt = '0;
                sel_upd = 1'b0;
            end
        endcase
    end

    // Only pulse-driven updates are compared; direction does not matter.
    assign hit_out = cfg_in.en && (cfg_in.src == cmsu_pkg::SRC_COUNTER) && sel_upd
                     && (sel_cnt == value_in);

endmodule : cmsu_slot_cmp

// ---- cmsu_counter_match_set_unit.sv ----
// Counter match set unit: compare slots, target actions and AHB-Lite registers.

// Functional notes
// - On counter equal to compare value, act on the target at once, not per scan.
// - Low direct outputs drive at once; higher outputs wait for scan end; markers at once.
// - Interrupt target raises one of eight counter interrupt requests, vectors 0 to 7.
// - While the counter interrupt mask flag is on, all eight requests are suppressed.
// - Cam target starts the axis cam named by its index at once if that cam setup is ready.
// - Active compares on one axis share one source kind; a mismatch reports an error.
// - Match counts whether the counter reaches the value counting up or down.
// - A set target bit stays set until a separate operation clears it.
// - Only pulse-driven counter updates are compared, never software rewrites.
// - Each match with an interrupt target gives exactly one request pulse while the mask flag is off; same-cycle matches on one vector share one pulse.
module cmsu_counter_match_set_unit (
    // Clock and reset.
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    // AHB-Lite slave.
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    // Axis pulse counters.
    input wire logic [31:0] X_AXIS_COUNTER_IN,
    input wire logic [31:0] Y_AXIS_COUNTER_IN,
    input wire logic [31:0] Z_AXIS_COUNTER_IN,
    input wire logic [2:0] CNT_PULSE_UPD_IN,
    // Program scan and cam engines.
    input wire logic SCAN_DONE_IN,
    input wire logic [2:0] CAM_CFG_READY_IN,
    // Target actions.
    output logic [7:0] DIRECT_OUT,
    output logic [7:0] DELAYED_OUT,
    output logic [15:0] MARKER_OUT,
    output logic [7:0] CNT_IRQ_REQ_OUT,
    output logic [2:0] CAM_START_OUT,
    output logic SRC_ERR_OUT,
    // Interrupt to the host.
    output logic IRQ_OUT
);

    localparam int unsigned NS = cmsu_pkg::NUM_SLOTS;
    localparam int unsigned NA = cmsu_pkg::NUM_AXES;

    // Bus pipeline state.
    cmsu_pkg::cmsu_aphase_s ap_q;
    cmsu_pkg::cmsu_aphase_s ap_d;
    logic hready_q;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic hresp_q;

    // Register file.
    logic mask_flag_q;
    logic [cmsu_pkg::STAT_W-1:0] status_q;
    logic [cmsu_pkg::STAT_W-1:0] status_d;
    logic [cmsu_pkg::STAT_W-1:0] irq_mask_q;
    logic [cmsu_pkg::TBIT_W-1:0] tbits_q;
    logic [cmsu_pkg::TBIT_W-1:0] tbits_d;
    cmsu_pkg::cmsu_cfg_s cfg_q [NS];
    logic [cmsu_pkg::CNT_W-1:0] val_q [NS];

    // Action registers.
    logic [cmsu_pkg::DELAY_W-1:0] delayed_q;
    logic [cmsu_pkg::NUM_VEC-1:0] irq_req_q;
    logic [NA-1:0] cam_start_q;
    logic src_err_q;
    logic irq_q;

    // Compare results and their decoded actions.
    logic [NS-1:0] hit;
    logic [cmsu_pkg::TBIT_W-1:0] set_vec;
    logic [cmsu_pkg::NUM_VEC-1:0] irq_vec;
    logic [NA-1:0] cam_vec;
    logic [3:0] kinds [NA];
    logic [NA-1:0] axis_err;
    logic src_err;

    // Address phase capture and register decode.
    wire accept = HREADY_IN;
    wire new_xfer = HSEL_IN && (HTRANS_IN != cmsu_pkg::HTRANS_IDLE) && HTRANS_IN[1];
    wire wr_fire = ap_q.valid && ap_q.write && HREADY_IN;
    wire rd_fill = ap_q.valid && !ap_q.write && !hready_q;
    wire [11:0] addr = ap_q.addr;
    wire sel_ctrl = (addr == cmsu_pkg::ADDR_CTRL);
    wire sel_status = (addr == cmsu_pkg::ADDR_STATUS);
    wire sel_mask = (addr == cmsu_pkg::ADDR_IRQ_MASK);
    wire sel_tbits = (addr == cmsu_pkg::ADDR_TBITS);
    wire in_slots = (addr >= cmsu_pkg::ADDR_SLOT_BASE) && (addr < cmsu_pkg::ADDR_SLOT_END);
    wire [11:0] slot_off = addr - cmsu_pkg::ADDR_SLOT_BASE;
    wire [2:0] slot_idx = slot_off[5:3];
    wire slot_is_val = slot_off[2];
    wire [cmsu_pkg::STAT_W-1:0] stat_w1c = (wr_fire && sel_status) ?
                                           HWDATA_IN[cmsu_pkg::STAT_W-1:0] : '0;
    wire [cmsu_pkg::TBIT_W-1:0] tbit_w1c = (wr_fire && sel_tbits) ? HWDATA_IN : '0;
    wire [NA*cmsu_pkg::CNT_W-1:0] cnt_all = {Z_AXIS_COUNTER_IN, Y_AXIS_COUNTER_IN,
                                             X_AXIS_COUNTER_IN};

    assign ap_d = accept ? '{valid: new_xfer, write: HWRITE_IN, addr: HADDR_IN[11:0]} : ap_q;

    // One compare per slot.
    genvar g;
    generate
        for (g = 0; g < NS; g++) begin : g_slot
            cmsu_slot_cmp u_cmp (
                .cfg_in(cfg_q[g]),
                .value_in(val_q[g]),
                .cnt_in(cnt_all),
                .pulse_upd_in(CNT_PULSE_UPD_IN),
                .hit_out(hit[g])
            );
        end
    endgenerate

    // Turn each hit into its target action.
    always_comb begin
        set_vec = '0;
        irq_vec = '0;
        cam_vec = '0;
        for (int s = 0; s < NS; s++) begin
            if (hit[s]) begin
                case (cfg_q[s].tgt)
                    cmsu_pkg::TGT_BIT: begin
                        set_vec[cfg_q[s].idx] = 1'b1;
                    end
                    cmsu_pkg::TGT_IRQ: begin
                        irq_vec[cfg_q[s].idx[2:0]] = 1'b1;
                    end
                    cmsu_pkg::TGT_CAM: begin
                        if (cfg_q[s].idx[1:0] != 2'h3) begin
                            cam_vec[cfg_q[s].idx[1:0]] = 1'b1;
                        end
                    end
                    default: begin
                        set_vec = set_vec;
                    end
                endcase
            end
        end
    end

    // Source kinds in use per axis; more than one kind on an axis is an error.
    always_comb begin
        for (int a = 0; a < NA; a++) begin
            kinds[a] = '0;
        end
        for (int s = 0; s < NS; s++) begin
            if (cfg_q[s].en && (cfg_q[s].axis != 2'h3)) begin
                kinds[cfg_q[s].axis][cfg_q[s].src] = 1'b1;
            end
        end
    end

    // An axis whose enabled slots use two or more source kinds is in error.
    generate
        for (g = 0; g < NA; g++) begin : g_axis
            assign axis_err[g] = (kinds[g] & (kinds[g] - 4'h1)) != 4'h0;
        end
    endgenerate
    assign src_err = |axis_err;

    // Hardware sets win over software clears.
    assign tbits_d = (tbits_q & ~tbit_w1c) | set_vec;
    assign status_d = (status_q & ~stat_w1c)
                      | {src_err, hit};

    // Read data of the captured address.
    always_comb begin
        hrdata_d = 32'h0000_0000;
        if (sel_ctrl) begin
            hrdata_d[cmsu_pkg::CTRL_MASK_BIT] = mask_flag_q;
        end else if (sel_status) begin
            hrdata_d[cmsu_pkg::STAT_W-1:0] = status_q;
        end else if (sel_mask) begin
            hrdata_d[cmsu_pkg::STAT_W-1:0] = irq_mask_q;
        end else if (sel_tbits) begin
            hrdata_d = tbits_q;
        end else if (in_slots && slot_is_val) begin
            hrdata_d = val_q[slot_idx];
        end else if (in_slots) begin
            hrdata_d[$bits(cmsu_pkg::cmsu_cfg_s)-1:0] = cfg_q[slot_idx];
        end
    end

    // Bus handshake: reads take one wait state so that data come from a register.
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            ap_q <= '0;
            hready_q <= 1'b1;
            hrdata_q <= 32'h0000_0000;
            hresp_q <= cmsu_pkg::HRESP_OKAY;
        end else begin
            ap_q <= ap_d;
            hresp_q <= cmsu_pkg::HRESP_OKAY;
            hready_q <= !(accept && new_xfer && !HWRITE_IN);
            hrdata_q <= rd_fill ? hrdata_d : hrdata_q;
        end
    end

    // Control, mask and slot registers written by software.
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            mask_flag_q <= cmsu_pkg::CTRL_MASK_RST;
            irq_mask_q <= cmsu_pkg::IRQ_MASK_RST;
        end else if (wr_fire && sel_ctrl) begin
            mask_flag_q <= HWDATA_IN[cmsu_pkg::CTRL_MASK_BIT];
        end else if (wr_fire && sel_mask) begin
            irq_mask_q <= HWDATA_IN[cmsu_pkg::STAT_W-1:0];
        end
    end

    always_ff @(posedge CLK_IN) begin
        for (int s = 0; s < NS; s++) begin
            if (SYS_RST_IN) begin
                cfg_q[s] <= cmsu_pkg::CFG_RST;
                val_q[s] <= cmsu_pkg::VAL_RST;
            end else if (wr_fire && in_slots && (slot_idx == s[2:0])) begin
                if (slot_is_val) begin
                    val_q[s] <= HWDATA_IN;
                end else begin
                    cfg_q[s] <= cmsu_pkg::cmsu_cfg_s'(HWDATA_IN[$bits(cmsu_pkg::cmsu_cfg_s)-1:0]);
                end
            end
        end
    end

    // Sticky target bits, status and the host interrupt.
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            tbits_q <= cmsu_pkg::TBITS_RST;
            status_q <= cmsu_pkg::STAT_RST;
            irq_q <= 1'b0;
            src_err_q <= 1'b0;
        end else begin
            tbits_q <= tbits_d;
            status_q <= status_d;
            irq_q <= |(status_d & irq_mask_q);
            src_err_q <= src_err;
        end
    end

    // Higher outputs follow the stored bits only at the end of a program scan.
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            delayed_q <= '0;
        end else if (SCAN_DONE_IN) begin
            delayed_q <= tbits_d[cmsu_pkg::DELAY_LO +: cmsu_pkg::DELAY_W];
        end
    end

    // Interrupt and cam start requests are one-cycle pulses per match.
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            irq_req_q <= '0;
            cam_start_q <= '0;
        end else begin
            irq_req_q <= mask_flag_q ? '0 : irq_vec;
            cam_start_q <= cam_vec & CAM_CFG_READY_IN;
        end
    end

    // Output wiring, all from registers.
    assign HRDATA_OUT = hrdata_q;
    assign HREADYOUT_OUT = hready_q;
    assign HRESP_OUT = hresp_q;
    assign DIRECT_OUT = tbits_q[cmsu_pkg::DIRECT_LO +: cmsu_pkg::DIRECT_W];
    assign DELAYED_OUT = delayed_q;
    assign MARKER_OUT = tbits_q[cmsu_pkg::MARK_LO +: cmsu_pkg::MARK_W];
    assign CNT_IRQ_REQ_OUT = irq_req_q;
    assign CAM_START_OUT = cam_start_q;
    assign SRC_ERR_OUT = src_err_q;
    assign IRQ_OUT = irq_q;

endmodule : cmsu_counter_match_set_unit

// ---- cmsu_assertions.sv ----
// Port-level concurrent checks of the counter match set unit.
module cmsu_assertions (
    // Clock, reset and bus.
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    input wire logic HREADYOUT_OUT,
    // Counter side and targets.
    input wire logic [2:0] CNT_PULSE_UPD_IN,
    input wire logic SCAN_DONE_IN,
    input wire logic [2:0] CAM_CFG_READY_IN,
    input wire logic [7:0] DIRECT_OUT,
    input wire logic [7:0] DELAYED_OUT,
    input wire logic [15:0] MARKER_OUT,
    input wire logic [7:0] CNT_IRQ_REQ_OUT,
    input wire logic [2:0] CAM_START_OUT,
    input wire logic SRC_ERR_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);
    logic take;
    logic wdone;
    logic wph_q;
    logic mask_q;
    logic [2:0] age_q;
    logic [11:0] adr_q;
    logic [23:0] bits;
    assign take = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
    assign wdone = wph_q && HREADY_IN;
    assign bits = {MARKER_OUT, DIRECT_OUT};
    // Shadow of the mask flag and the age of the last completed write.
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            wph_q <= 1'b0;
            mask_q <= 1'b0;
            age_q <= 3'h7;
        end else begin
            if (HREADY_IN) begin
                wph_q <= take && HWRITE_IN;
            end
            if (take) begin
                adr_q <= HADDR_IN[11:0];
            end
            if (wdone && adr_q == cmsu_pkg::ADDR_CTRL) begin
                mask_q <= HWDATA_IN[cmsu_pkg::CTRL_MASK_BIT];
            end
            age_q <= wdone ? 3'h0 : ((age_q == 3'h7) ? age_q : age_q + 3'h1);
        end
    end
    property p_mask_quiet;
        $past(mask_q) |-> CNT_IRQ_REQ_OUT == 8'h0;
    endproperty
    a_mask_quiet: assert property (p_mask_quiet) else $error("irq pulse while masked");
    property p_no_strobe;
        CNT_PULSE_UPD_IN == 3'h0 |=> CNT_IRQ_REQ_OUT == 8'h0 && CAM_START_OUT == 3'h0;
    endproperty
    a_no_strobe: assert property (p_no_strobe) else $error("pulse without strobe");
    property p_cam_ready;
        CAM_START_OUT != 3'h0 |-> (CAM_START_OUT & ~$past(CAM_CFG_READY_IN)) == 3'h0;
    endproperty
    a_cam_ready: assert property (p_cam_ready) else $error("cam start while unready");
    property p_bit_rise;
        (bits & ~$past(bits)) != 24'h0 |-> $past(CNT_PULSE_UPD_IN) != 3'h0;
    endproperty
    a_bit_rise: assert property (p_bit_rise) else $error("bit set without strobe");
    property p_sticky;
        ($past(bits) & ~bits) != 24'h0 |-> $past(wdone) && $past(adr_q) == cmsu_pkg::ADDR_TBITS;
    endproperty
    a_sticky: assert property (p_sticky) else $error("target bit dropped");
    property p_scan_only;
        DELAYED_OUT != $past(DELAYED_OUT) |-> $past(SCAN_DONE_IN);
    endproperty
    a_scan_only: assert property (p_scan_only) else $error("delayed bits moved");
    property p_err_write;
        SRC_ERR_OUT != $past(SRC_ERR_OUT) |-> age_q < 3'h3;
    endproperty
    a_err_write: assert property (p_err_write) else $error("error flag moved alone");
    property p_read_wait;
        take && !HWRITE_IN |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
    c_irq: cover property (CNT_IRQ_REQ_OUT != 8'h0);
    c_cam: cover property (CAM_START_OUT != 3'h0);
    c_scan: cover property (DELAYED_OUT != 8'h0);
endmodule : cmsu_assertions

bind cmsu_counter_match_set_unit cmsu_assertions u_chk (.CLK_IN(CLK_IN),
    .SYS_RST_IN(SYS_RST_IN), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN),
    .HWRITE_IN(HWRITE_IN), .HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADY_IN),
    .HREADYOUT_OUT(HREADYOUT_OUT), .CNT_PULSE_UPD_IN(CNT_PULSE_UPD_IN),
    .SCAN_DONE_IN(SCAN_DONE_IN), .CAM_CFG_READY_IN(CAM_CFG_READY_IN), .DIRECT_OUT(DIRECT_OUT),
    .DELAYED_OUT(DELAYED_OUT), .MARKER_OUT(MARKER_OUT), .CNT_IRQ_REQ_OUT(CNT_IRQ_REQ_OUT),
    .CAM_START_OUT(CAM_START_OUT), .SRC_ERR_OUT(SRC_ERR_OUT));

// ---- cmsu_axis_model.sv ----
// Axis pulse counters and program scan engine feeding the compare unit.
module cmsu_axis_model (
    // Clock.
    input wire logic clk_in,
    // Counter values, update strobes and scan end.
    output logic [31:0] x_cnt_out,
    output logic [31:0] y_cnt_out,
    output logic [31:0] z_cnt_out,
    output logic [2:0] upd_out,
    output logic scan_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cnt_q [3];
    assign x_cnt_out = cnt_q[0];
    assign y_cnt_out = cnt_q[1];
    assign z_cnt_out = cnt_q[2];
    initial begin
        cnt_q = '{32'h0, 32'h0, 32'h0};
        upd_out = 3'h0;
        scan_out = 1'b0;
    end
    // Counters run enabled; each input pulse moves a value and, if strobe is set, strobes it once.
    task automatic count(input int ax, input logic [31:0] v, input logic strobe);
        @(posedge clk_in);
        cnt_q[ax] <= v;
        upd_out[ax] <= strobe;
        @(posedge clk_in);
        upd_out <= 3'h0;
        #1;
    endtask : count
    task automatic scan();
        @(posedge clk_in);
        scan_out <= 1'b1;
        @(posedge clk_in);
        scan_out <= 1'b0;
        #1;
    endtask : scan
endmodule : cmsu_axis_model

// ---- cmsu_counter_match_set_unit_tb.sv ----
// Self-checking bench of the counter match set unit with a bench-side model.
module cmsu_counter_match_set_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, hsel, hwrite, hready, hresp, scan, err, irq;
    logic [1:0] htrans;
    logic [2:0] upd, cam_rdy, cam;
    logic [7:0] dir, dly, irqv;
    logic [15:0] mrk;
    logic [31:0] haddr, hwdata, hrdata, xc, yc, zc, r, val, exp_tb, exp_st;
    logic [7:0] exp_dl;
    int bad_count = 0;
    int total_checks = 0;
    int idx;
    int q[$];
    cmsu_counter_match_set_unit dut (.CLK_IN(clk), .SYS_RST_IN(rst), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
        .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
        .HRESP_OUT(hresp), .X_AXIS_COUNTER_IN(xc), .Y_AXIS_COUNTER_IN(yc),
        .Z_AXIS_COUNTER_IN(zc), .CNT_PULSE_UPD_IN(upd), .SCAN_DONE_IN(scan),
        .CAM_CFG_READY_IN(cam_rdy), .DIRECT_OUT(dir), .DELAYED_OUT(dly), .MARKER_OUT(mrk),
        .CNT_IRQ_REQ_OUT(irqv), .CAM_START_OUT(cam), .SRC_ERR_OUT(err), .IRQ_OUT(irq));
    cmsu_axis_model ax (.clk_in(clk), .x_cnt_out(xc), .y_cnt_out(yc), .z_cnt_out(zc),
        .upd_out(upd), .scan_out(scan));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= cmsu_pkg::HTRANS_IDLE;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        r = hrdata;
        #1;
    endtask : bus
    function automatic logic [31:0] cfg(input int a, input int s, input int t, input int i);
        return {20'h0, 5'(i), 2'(t), 2'(s), 2'(a), 1'b1};
    endfunction : cfg
    function automatic logic [11:0] slot(input int n);
        return cmsu_pkg::ADDR_SLOT_BASE + 12'(8 * n);
    endfunction : slot
    task automatic outs();
        check({mrk, dly, dir}, {exp_tb[31:16], exp_dl, exp_tb[7:0]});
    endtask : outs
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up();
    end
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        rst = 1'b1;
        cam_rdy = 3'h5;
        {exp_tb, exp_st, exp_dl} = '0;
        void'($urandom(91));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        q = '{0, 4, 8, 12, 16, 20, 256};
        foreach (q[i]) begin
            bus(1'b0, 12'(q[i]), 32'h0);
            check(r, 32'h0);
            check(hresp, 32'(cmsu_pkg::HRESP_OKAY));
        end
        bus(1'b1, cmsu_pkg::ADDR_IRQ_MASK, 32'h1);
        for (int i = 0; i < 4; i++) begin
            idx = i * 8 + $urandom_range(7, 0);
            val = $urandom;
            bus(1'b1, slot(0), cfg(0, 0, 0, idx));
            bus(1'b1, slot(0) + 12'h004, val);
            ax.count(0, val - 32'h1, 1'b1);
            ax.count(0, val, 1'b0);
            outs();
            ax.count(0, val, 1'b1);
            exp_tb[idx] = 1'b1;
            exp_st[0] = 1'b1;
            outs();
            check(irq, 32'h1);
            ax.count(0, val + 32'h2, 1'b1);
            ax.scan();
            exp_dl = exp_tb[15:8];
            outs();
            bus(1'b1, cmsu_pkg::ADDR_TBITS, 32'h1 << idx);
            exp_tb[idx] = 1'b0;
            outs();
            ax.count(0, val, 1'b1);
            exp_tb[idx] = 1'b1;
            outs();
        end
        // Each vector is the target of one slot only at a time.
        for (int v = 0; v < 8; v++) begin
            val = $urandom;
            bus(1'b1, slot(2), cfg(2, 0, 1, v));
            bus(1'b1, slot(2) + 12'h004, val);
            ax.count(2, val, 1'b1);
            check(irqv, 32'h1 << v);
            @(posedge clk);
            #1;
            check(irqv, 32'h0);
        end
        exp_st[2] = 1'b1;
        bus(1'b1, cmsu_pkg::ADDR_CTRL, 32'h1);
        ax.count(2, val, 1'b1);
        check(irqv, 32'h0);
        bus(1'b1, cmsu_pkg::ADDR_CTRL, 32'h0);
        ax.count(2, val, 1'b1);
        check(irqv, 32'h80);
        for (int a = 0; a < 3; a++) begin
            val = $urandom;
            bus(1'b1, slot(3), cfg(1, 0, 2, a));
            bus(1'b1, slot(3) + 12'h004, val);
            ax.count(1, val, 1'b1);
            check(cam, cam_rdy[a] ? 32'h1 << a : 32'h0);
        end
        exp_st[3] = 1'b1;
        bus(1'b1, slot(4), cfg(0, 1, 3, 0));
        repeat (3) @(posedge clk);
        #1;
        check(err, 32'h1);
        exp_st[7] = 1'b1;
        bus(1'b1, slot(4), 32'h0);
        repeat (3) @(posedge clk);
        #1;
        check(err, 32'h0);
        bus(1'b0, cmsu_pkg::ADDR_STATUS, 32'h0);
        check(r, exp_st);
        bus(1'b1, cmsu_pkg::ADDR_STATUS, exp_st);
        @(posedge clk);
        #1;
        check(irq, 32'h0);
        wrap_up();
    end
endmodule : cmsu_counter_match_set_unit_tb
